// >>> smb_top.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
// Contract
// - Eight independent access slots, each one management transaction.
// - Management clock 2.5 MHz after reset; speed bit picks 4 MHz (half period rounded up to 5 cycles).
// - Master scans done bits round robin, launching any slot with done 0.
// - On completion set that slot's done bit, then examine next slot.
// - PHY one answers port address 1, PHY two address 2, fixed.
// - Frame type 0 gives Clause 45 framing, 1 gives Clause 22.
// - Opcode: 0 address, 1 write, 2 incrementing read, 3 read.
// - Clause 45 read leaves the 16-bit register content in slot data.
// - Incrementing reads return successive registers, each into its own slot.
// - Clause 22 uses one slot: register in device field, data in slot.
// - Slots run in order, so last armed done means all finished.
// - PHY MMDs: 0x01 PMA, 0x03 PCS, 0x07 autoneg, 0x1E vendor.
// - Standard registers up to 0x7FFF, vendor registers 0x8000 to 0xFFFF.
// - Five-bit port and device fields name 32 ports and 32 devices.
// - Configuration straps are captured just after reset release.
module smb_top (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic [3:0]  I_HW_CFG,
  output logic             O_MDC,
  output logic             O_MDIO_O,
  output logic             O_MDIO_OE,
  input  wire logic        I_MDIO_I
);
  localparam int N = smb_pkg::SLOTS;

  smb_pkg::smb_slot_type  slot_ff [N];
  logic [N-1:0]           done_ff;
  logic                   speed_ff;
  logic [3:0]             strap_ff;
  logic                   rst_q_ff;
  smb_pkg::smb_state_type state_ff;
  logic [2:0]             ptr_ff;
  logic [2:0]             act_ff;
  logic [31:0]            prdata_ff;

  wire                    setup    = I_PSEL && !I_PENABLE;
  wire                    access   = I_PSEL && I_PENABLE;
  wire                    aligned  = I_PADDR[1:0] == 2'h0;
  wire                    hit_slot = aligned && I_PADDR[7:5] == smb_pkg::SLOT0_OFF[7:5];
  wire                    hit_cfg  = I_PADDR == smb_pkg::CFG_OFF;
  wire                    hit_stat = I_PADDR == smb_pkg::STAT_OFF;
  wire                    mapped   = hit_slot || hit_cfg || hit_stat;
  wire                    wr_en    = access && I_PWRITE;
  wire [2:0]              widx     = I_PADDR[4:2];
  wire                    mdio_done;
  wire                    mdio_busy;
  wire [15:0]             rdata;
  wire                    rise;
  wire                    fall;
  wire                    start;
  wire                    cur_c22;
  wire                    cur_read;
  wire                    act_read;
  wire [1:0]              st_bits;
  wire [1:0]              op_bits;
  smb_pkg::smb_slot_type  cur;
  smb_pkg::smb_slot_type  act;
  smb_pkg::smb_req_type   req;
  logic [31:0]            rd_mux;

  assign cur      = slot_ff[ptr_ff];
  assign act      = slot_ff[act_ff];
  assign start    = state_ff == smb_pkg::SMB_IDLE && !done_ff[ptr_ff];
  assign cur_c22  = cur.ft == smb_pkg::FT_C22;
  assign cur_read = cur.op == smb_pkg::OP_RD || cur.op == smb_pkg::OP_INC_RD;
  assign act_read = act.op == smb_pkg::OP_RD || act.op == smb_pkg::OP_INC_RD
                    || (act.ft == smb_pkg::FT_C22 && act.op != smb_pkg::OP_WR);

  // Clause 22 has only write and read; anything but write reads
  assign st_bits  = cur_c22 ? smb_pkg::ST_C22 : smb_pkg::ST_C45;
  assign op_bits  = !cur_c22 ? cur.op :
                    (cur.op == smb_pkg::OP_WR ? smb_pkg::C22_OP_WR : smb_pkg::C22_OP_RD);
  assign req.read = cur_read || (cur_c22 && cur.op != smb_pkg::OP_WR);
  // Port and device fields pass through unchanged, full 5 bits each
  assign req.frame = {smb_pkg::PREAMBLE, st_bits, op_bits, cur.prt, cur.dev,
                      req.read ? smb_pkg::TA_READ : smb_pkg::TA_WRITE,
                      req.read ? 16'hFFFF : cur.data};

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (hit_slot)
    begin
      rd_mux[smb_pkg::DATA_LSB +: 16] = slot_ff[widx].data;
      rd_mux[smb_pkg::ADR_LSB  +: 5]  = slot_ff[widx].dev;
      rd_mux[smb_pkg::PRT_LSB  +: 5]  = slot_ff[widx].prt;
      rd_mux[smb_pkg::OP_LSB   +: 2]  = slot_ff[widx].op;
      rd_mux[smb_pkg::FT_LSB   +: 2]  = slot_ff[widx].ft;
      rd_mux[smb_pkg::DONE_BIT]       = done_ff[widx];
    end
    else if (hit_cfg)
      rd_mux[smb_pkg::SPEED_BIT] = speed_ff;
    else if (hit_stat)
      rd_mux = {20'h00000, strap_ff, 4'h0, act_ff, mdio_busy};
  end

  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = access && !mapped;
  assign O_PRDATA  = prdata_ff;

  // Read data is latched in the setup phase so the access phase needs no wait
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
      prdata_ff <= 32'h00000000;
    else if (setup)
      prdata_ff <= rd_mux;
  end

  // Slot storage; hardware completion wins over a host write in the same cycle
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      for (int i = 0; i < N; i++)
        slot_ff[i] <= '0;
      done_ff <= {N{smb_pkg::DONE_RST}};
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        if (wr_en && hit_slot && widx == 3'(i))
        begin
          slot_ff[i].data <= I_PWDATA[smb_pkg::DATA_LSB +: 16];
          slot_ff[i].dev  <= I_PWDATA[smb_pkg::ADR_LSB +: 5];
          slot_ff[i].prt  <= I_PWDATA[smb_pkg::PRT_LSB +: 5];
          slot_ff[i].op   <= I_PWDATA[smb_pkg::OP_LSB +: 2];
          slot_ff[i].ft   <= I_PWDATA[smb_pkg::FT_LSB +: 2];
          done_ff[i]      <= I_PWDATA[smb_pkg::DONE_BIT];
        end
        if (mdio_done && act_ff == 3'(i))
        begin
          done_ff[i] <= 1'b1;
          if (act_read)
            slot_ff[i].data <= rdata;
        end
      end
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
      speed_ff <= smb_pkg::SPEED_RST;
    else if (wr_en && hit_cfg)
      speed_ff <= I_PWDATA[smb_pkg::SPEED_BIT];
  end

  // Straps are taken on the first edge after reset release
  always_ff @(posedge I_SYS_CLK)
  begin
    rst_q_ff <= I_RST;
    if (I_RST)
      strap_ff <= 4'h0;
    else if (rst_q_ff)
      strap_ff <= I_HW_CFG;
  end

  // Round-robin scheduler over the slots
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      state_ff <= smb_pkg::SMB_IDLE;
      ptr_ff   <= 3'h0;
      act_ff   <= 3'h0;
    end
    else
    begin
      unique case (state_ff)
        smb_pkg::SMB_IDLE:
        begin
          if (start)
          begin
            state_ff <= smb_pkg::SMB_RUN;
            act_ff   <= ptr_ff;
          end
          else
            ptr_ff <= 3'(ptr_ff + 3'h1);
        end
        smb_pkg::SMB_RUN:
        begin
          if (mdio_done)
          begin
            state_ff <= smb_pkg::SMB_IDLE;
            ptr_ff   <= 3'(act_ff + 3'h1);
          end
        end
      endcase
    end
  end

  smb_mdc_gen u_mdc (
    .i_clk  (I_SYS_CLK),
    .i_rst  (I_RST),
    .i_run  (mdio_busy),
    .i_fast (speed_ff),
    .o_mdc  (O_MDC),
    .o_rise (rise),
    .o_fall (fall)
  );

  smb_mdio_shift u_shift (
    .i_clk     (I_SYS_CLK),
    .i_rst     (I_RST),
    .i_start   (start),
    .i_req     (req),
    .i_rise    (rise),
    .i_fall    (fall),
    .i_mdio_i  (I_MDIO_I),
    .o_busy    (mdio_busy),
    .o_done    (mdio_done),
    .o_rdata   (rdata),
    .o_mdio_o  (O_MDIO_O),
    .o_mdio_oe (O_MDIO_OE)
  );

  default clocking @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);

  property p_launch;
    state_ff == smb_pkg::SMB_IDLE && !done_ff[ptr_ff]
      |=> state_ff == smb_pkg::SMB_RUN && act_ff == $past(ptr_ff) ##1 mdio_busy;
  endproperty
  a_launch: assert property (p_launch) else $error("pending slot not launched");

  property p_done;
    state_ff == smb_pkg::SMB_RUN && mdio_done
      |=> done_ff[$past(act_ff)] && ptr_ff == 3'($past(act_ff) + 3'h1);
  endproperty
  a_done: assert property (p_done) else $error("done not set or pointer stuck");

  property p_skip;
    state_ff == smb_pkg::SMB_IDLE && done_ff[ptr_ff]
      |=> state_ff == smb_pkg::SMB_IDLE && ptr_ff == 3'($past(ptr_ff) + 3'h1);
  endproperty
  a_skip: assert property (p_skip) else $error("idle slot not skipped in order");

  property p_st;
    start |-> req.frame[31:30] == (cur.ft == smb_pkg::FT_C22 ? 2'h1 : 2'h0);
  endproperty
  a_st: assert property (p_st) else $error("start code does not match frame type");

  property p_op;
    start && cur.ft == smb_pkg::FT_C45 |-> req.frame[29:28] == cur.op
      && req.read == (cur.op[1] == 1'b1);
  endproperty
  a_op: assert property (p_op) else $error("Clause 45 opcode mismatch");

  property p_port;
    start |-> req.frame[27:23] == cur.prt && req.frame[22:18] == cur.dev;
  endproperty
  a_port: assert property (p_port) else $error("port or device field mismatch");

  property p_rdata;
    state_ff == smb_pkg::SMB_RUN && mdio_done && act_read
      |=> slot_ff[$past(act_ff)].data == $past(rdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not stored in slot");

  property p_speed;
    $fell(I_RST) |-> speed_ff == 1'b0 ##1 !mdio_busy || !O_MDC;
  endproperty
  a_speed: assert property (p_speed) else $error("clock speed not slow after reset");

  property p_c22;
    start && cur.ft == smb_pkg::FT_C22 && cur.op == smb_pkg::OP_RD
      |-> req.frame[29:28] == 2'h2 && req.read;
  endproperty
  a_c22: assert property (p_c22) else $error("Clause 22 read not framed as read");

endmodule

// >>> smb_pkg.sv
package smb_pkg;

  localparam int          SLOTS         = 8;
  // Register byte offsets
  localparam logic [7:0]  SLOT0_OFF     = 8'h00;
  localparam logic [7:0]  CFG_OFF       = 8'h20;
  localparam logic [7:0]  STAT_OFF      = 8'h24;
  // Slot word layout
  localparam int          DATA_LSB      = 0;
  localparam int          ADR_LSB       = 16;
  localparam int          PRT_LSB       = 21;
  localparam int          OP_LSB        = 26;
  localparam int          FT_LSB        = 28;
  localparam int          DONE_BIT      = 31;
  localparam int          SPEED_BIT     = 0;
  // Reset values
  localparam logic        DONE_RST      = 1'b1;
  localparam logic        SPEED_RST     = 1'b0;
  // Frame type and opcode codes
  localparam logic [1:0]  FT_C45        = 2'h0;
  localparam logic [1:0]  FT_C22        = 2'h1;
  localparam logic [1:0]  OP_ADDR       = 2'h0;
  localparam logic [1:0]  OP_WR         = 2'h1;
  localparam logic [1:0]  OP_INC_RD     = 2'h2;
  localparam logic [1:0]  OP_RD         = 2'h3;
  localparam logic [1:0]  ST_C45        = 2'h0;
  localparam logic [1:0]  ST_C22        = 2'h1;
  localparam logic [1:0]  C22_OP_WR     = 2'h1;
  localparam logic [1:0]  C22_OP_RD     = 2'h2;
  localparam logic [1:0]  TA_WRITE      = 2'h2;
  localparam logic [1:0]  TA_READ       = 2'h3;
  // Fixed PHY port addresses and manageable devices
  localparam logic [4:0]  PHY1_ADDR     = 5'h01;
  localparam logic [4:0]  PHY2_ADDR     = 5'h02;
  localparam logic [4:0]  MMD_PMA       = 5'h01;
  localparam logic [4:0]  MMD_PCS       = 5'h03;
  localparam logic [4:0]  MMD_AN        = 5'h07;
  localparam logic [4:0]  MMD_VEND1     = 5'h1E;
  localparam logic [15:0] STD_REG_LAST  = 16'h7FFF;
  localparam logic [15:0] VEND_REG_FRST = 16'h8000;
  localparam logic [15:0] VEND_REG_LAST = 16'hFFFF;
  // Frame geometry
  localparam int          FRAME_BITS    = 64;
  localparam logic [5:0]  TA_IDX        = 6'h2E;
  localparam logic [5:0]  DATA_IDX      = 6'h30;
  localparam logic [5:0]  LAST_IDX      = 6'h3F;
  localparam logic [31:0] PREAMBLE      = 32'hFFFFFFFF;
  // Management clock timing
  localparam int          SYS_KHZ       = 40000;
  localparam int          MDC_SLOW_KHZ  = 2500;
  localparam int          MDC_FAST_KHZ  = 4166;
  localparam logic [3:0]  HALF_SLOW     =
    4'((SYS_KHZ + 2 * MDC_SLOW_KHZ - 1) / (2 * MDC_SLOW_KHZ));
  localparam logic [3:0]  HALF_FAST     =
    4'((SYS_KHZ + 2 * MDC_FAST_KHZ - 1) / (2 * MDC_FAST_KHZ));

  typedef struct packed {
    logic [1:0]  ft;
    logic [1:0]  op;
    logic [4:0]  prt;
    logic [4:0]  dev;
    logic [15:0] data;
  } smb_slot_type;

  typedef struct packed {
    logic        read;
    logic [63:0] frame;
  } smb_req_type;

  typedef enum logic {
    SMB_IDLE = 1'b0,
    SMB_RUN  = 1'b1
  } smb_state_type;

endpackage

// >>> smb_mdc_gen.sv
`timescale 1ns/1ps
module smb_mdc_gen (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_run,
  input  wire logic i_fast,
  output logic      o_mdc,
  output logic      o_rise,
  output logic      o_fall
);
  logic [3:0] cnt_ff;
  logic       mdc_ff;
  logic [3:0] half;
  logic       tick;

  assign half   = i_fast ? smb_pkg::HALF_FAST : smb_pkg::HALF_SLOW;
  assign tick   = i_run && (cnt_ff == 4'(half - 4'h1));
  assign o_rise = tick && !mdc_ff;
  assign o_fall = tick && mdc_ff;
  assign o_mdc  = mdc_ff;

  // Clock idles low between frames
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_run)
    begin
      cnt_ff <= 4'h0;
      mdc_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= tick ? 4'h0 : 4'(cnt_ff + 4'h1);
      mdc_ff <= tick ? !mdc_ff : mdc_ff;
    end
  end
endmodule

// >>> smb_mdio_shift.sv
`timescale 1ns/1ps
module smb_mdio_shift (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_start,
  input  wire smb_pkg::smb_req_type i_req,
  input  wire logic                 i_rise,
  input  wire logic                 i_fall,
  input  wire logic                 i_mdio_i,
  output logic                      o_busy,
  output logic                      o_done,
  output logic [15:0]               o_rdata,
  output logic                      o_mdio_o,
  output logic                      o_mdio_oe
);
  logic [2:0]  sync_ff;
  logic        mdio_s_ff;
  logic [63:0] sh_ff;
  logic [5:0]  bit_ff;
  logic        busy_ff;
  logic        rd_ff;
  logic        done_ff;
  logic [15:0] rdata_ff;
  logic        rd_phase;
  logic        last;

  assign rd_phase  = rd_ff && (bit_ff >= smb_pkg::TA_IDX);
  assign last      = bit_ff == smb_pkg::LAST_IDX;
  assign o_busy    = busy_ff;
  assign o_done    = done_ff;
  assign o_rdata   = rdata_ff;
  assign o_mdio_o  = sh_ff[63];
  assign o_mdio_oe = busy_ff && !rd_phase;

  // Three-stage synchroniser; a change counts once stages two and three agree
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sync_ff   <= 3'h7;
      mdio_s_ff <= 1'b1;
    end
    else
    begin
      sync_ff   <= {sync_ff[1:0], i_mdio_i};
      mdio_s_ff <= (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : mdio_s_ff;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sh_ff    <= 64'hFFFFFFFFFFFFFFFF;
      bit_ff   <= 6'h00;
      busy_ff  <= 1'b0;
      rd_ff    <= 1'b0;
      done_ff  <= 1'b0;
      rdata_ff <= 16'h0000;
    end
    else
    begin
      done_ff <= busy_ff && i_fall && last;
      if (!busy_ff && i_start)
      begin
        sh_ff   <= i_req.frame;
        bit_ff  <= 6'h00;
        busy_ff <= 1'b1;
        rd_ff   <= i_req.read;
      end
      else if (busy_ff && i_fall)
      begin
        sh_ff   <= {sh_ff[62:0], 1'b1};
        bit_ff  <= 6'(bit_ff + 6'h01);
        busy_ff <= !last;
      end
      // Sampled at the end of each bit: the synchroniser delay of four cycles is close to the five-cycle fast half period
      if (busy_ff && i_fall && rd_ff && bit_ff >= smb_pkg::DATA_IDX)
        rdata_ff <= {rdata_ff[14:0], mdio_s_ff};
    end
  end

  property p_edge;
    @(posedge i_clk) disable iff (i_rst)
    !(i_rise && i_fall);
  endproperty
  a_edge: assert property (p_edge) else $error("clock rise and fall in one cycle");
endmodule

// >>> smb_phy_model.sv
`timescale 1ns/1ps
module smb_phy_model (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_mdc,
  input  wire logic i_mdio,
  output logic      o_mdio,
  output logic      o_oe
);
  logic [15:0] mem [logic [26:0]];
  logic [15:0] adr [logic [9:0]];
  logic [63:0] sh;
  logic [13:0] f;
  logic [26:0] key;
  logic [15:0] rd;
  logic        mdc_q;
  logic        hit;
  logic        rdq;
  int          cnt;
  function automatic logic [15:0] val(input logic [26:0] k);
    if (mem.exists(k))
      return mem[k];
    return k[15:0] ^ {6'h15, k[25:16]};
  endfunction
  always @(posedge i_clk)
  begin
    mdc_q <= i_mdc;
    if (i_rst)
    begin
      cnt = 0;
      rdq = 1'b0;
      o_oe <= 1'b0;
      o_mdio <= 1'b1;
    end
    else if (i_mdc && !mdc_q)
    begin
      sh = {sh[62:0], i_mdio};
      cnt++;
      if (cnt == 46)
      begin
        // Start, opcode, port and device fields are complete here
        f = sh[13:0];
        hit = f[9:5] inside {5'h01, 5'h02};
        if (!adr.exists(f[9:0]))
          adr[f[9:0]] = 16'h0000;
        key = (f[13:12] == 2'h1) ? {1'b1, f[9:0], 16'h0000} : {1'b0, f[9:0], adr[f[9:0]]};
        rdq = hit && ((f[13:12] == 2'h1) ? (f[11:10] == 2'h2) : f[11]);
        rd = val(key);
        if (hit && f[13:12] != 2'h1 && f[11:10] == 2'h2)
          adr[f[9:0]]++;
      end
      if (cnt == 64)
      begin
        if (hit && f[13:12] != 2'h1 && f[11:10] == 2'h0)
          adr[f[9:0]] = sh[15:0];
        else if (hit && f[11:10] == 2'h1)
          mem[key] = sh[15:0];
        cnt = 0;
        rdq = 1'b0;
      end
    end
    else if (!i_mdc && mdc_q)
    begin
      // Turnaround zero, then read data MSB first, released after the last bit
      o_oe <= rdq && cnt >= 47 && cnt < 64;
      o_mdio <= (cnt >= 48 && cnt < 64) ? rd[63-cnt] : 1'b0;
    end
  end
endmodule

// >>> test_spi_to_mdio_bridge.sv
`timescale 1ns/1ps
module test_spi_to_mdio_bridge;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  hw = 4'h0;
  logic        mdc;
  logic        mo;
  logic        moe;
  logic        po;
  logic        poe;
  wire logic   mdio = moe ? mo : (poe ? po : 1'b1);
  logic [31:0] exq [8];
  logic [15:0] bmem [logic [26:0]];
  logic [15:0] ba [logic [9:0]];
  logic [31:0] r;
  logic        e;
  logic        mq;
  logic [4:0]  p;
  logic [4:0]  d;
  logic [15:0] a;
  int          failures = 0;
  int          cmp_count = 0;
  int          per = 0;
  int          cc = 0;
  smb_top smb_top_i (.I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_HW_CFG(hw), .O_MDC(mdc),
    .O_MDIO_O(mo), .O_MDIO_OE(moe), .I_MDIO_I(mdio));
  smb_phy_model smb_phy_model_i (.i_clk(clk), .i_rst(rst), .i_mdc(mdc), .i_mdio(mdio),
    .o_mdio(po), .o_oe(poe));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    mq <= mdc;
    cc++;
    if (mdc && !mq)
    begin
      per = cc;
      cc = 0;
    end
  end
  task automatic finish_test();
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1 && ++k < 100);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [15:0] bm(input logic [1:0] ft, input logic [1:0] op,
    input logic [4:0] pp, input logic [4:0] dd, input logic [15:0] v);
    logic [26:0] k;
    logic        rdop;
    if (!ba.exists({pp, dd}))
      ba[{pp, dd}] = 16'h0000;
    k = (ft == smb_pkg::FT_C22) ? {1'b1, pp, dd, 16'h0000} : {1'b0, pp, dd, ba[{pp, dd}]};
    rdop = (ft == smb_pkg::FT_C22) ? (op != smb_pkg::OP_WR) : op[1];
    if (!(pp inside {5'h01, 5'h02}))
      return rdop ? 16'hFFFF : v;
    if (rdop)
    begin
      v = bmem.exists(k) ? bmem[k] : (k[15:0] ^ {6'h15, k[25:16]});
      if (ft != smb_pkg::FT_C22 && op == smb_pkg::OP_INC_RD)
        ba[{pp, dd}]++;
    end
    else if (ft != smb_pkg::FT_C22 && op == smb_pkg::OP_ADDR)
      ba[{pp, dd}] = v;
    else
      bmem[k] = v;
    return v;
  endfunction
  task automatic arm(input int n, input logic [1:0] ft, input logic [1:0] op,
    input logic [4:0] pp, input logic [4:0] dd, input logic [15:0] v);
    apb(1'b1, 8'(4 * n), {2'b00, ft, op, pp, dd, v});
    exq[n] = {2'b10, ft, op, pp, dd, bm(ft, op, pp, dd, v)};
  endtask
  task automatic wait_chk(input int lo, input int hi);
    for (int k = 0; k < 4000; k++)
    begin
      apb(1'b0, 8'(4 * hi), 32'h00000000);
      if (r[31] === 1'b1)
        break;
    end
    for (int n = lo; n <= hi; n++)
    begin
      apb(1'b0, 8'(4 * n), 32'h00000000);
      chk(r, exq[n]);
    end
  endtask
  initial
  begin
    #(70000 * 25);
    failures++;
    finish_test();
  end
  initial
  begin
    void'($urandom(75));
    hw = 4'($urandom);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int n = 0; n < 8; n++)
    begin
      apb(1'b0, 8'(4 * n), 32'h00000000);
      chk(r, 32'h80000000);
    end
    apb(1'b0, smb_pkg::CFG_OFF, 32'h00000000);
    chk(r, 32'h00000000);
    apb(1'b0, smb_pkg::STAT_OFF, 32'h00000000);
    chk({28'h0000000, r[11:8]}, {28'h0000000, hw});
    apb(1'b0, 8'h28, 32'h00000000);
    chk({r[30:0], e}, 32'h00000001);
    p = 5'(1 + $urandom % 2);
    d = (5'h01 << ($urandom % 2)) | (($urandom % 2) ? 5'h04 : 5'h00);
    a = 16'($urandom);
    arm(0, smb_pkg::FT_C45, smb_pkg::OP_ADDR, p, d, a);
    arm(1, smb_pkg::FT_C45, smb_pkg::OP_WR, p, d, 16'($urandom));
    arm(2, smb_pkg::FT_C45, smb_pkg::OP_RD, p, d, 16'h0000);
    wait_chk(0, 2);
    chk(32'(per), 32'h00000010);
    a = 16'h7FFE;
    arm(3, smb_pkg::FT_C45, smb_pkg::OP_ADDR, p, smb_pkg::MMD_VEND1, a);
    for (int n = 4; n < 8; n++)
      arm(n, smb_pkg::FT_C45, smb_pkg::OP_INC_RD, p, smb_pkg::MMD_VEND1, 16'h0000);
    wait_chk(3, 7);
    apb(1'b1, smb_pkg::CFG_OFF, 32'h00000001);
    d = 5'($urandom);
    arm(0, smb_pkg::FT_C22, smb_pkg::OP_WR, p, d, 16'($urandom));
    arm(1, smb_pkg::FT_C22, smb_pkg::OP_RD, p, d, 16'h0000);
    arm(2, smb_pkg::FT_C22, smb_pkg::OP_RD, 5'h03, d, 16'h0000);
    wait_chk(0, 2);
    chk(32'(per), 32'h0000000A);
    finish_test();
  end
endmodule
